// *** rtl/vpm_upper_map_regs.sv ***
// Upper virtual partition map registers, valid bits and access checking
//
// What this block does
// - Register six holds physical entries for virtual identifiers 24-27.
// - Register seven holds physical entries for virtual identifiers 28-31.
// - Four 16-bit entries per register, lowest identifier in bits 15:0.
// - Highest map register index reports last implemented register, max 7.
// - Index zero means only map register zero exists.
// - Kernel and user identifiers translate only under their own enables.
// - Entry n is valid only while valid bit n is one.
// - Register six exists only with hypervisor control and index above 5.
// - Register seven exists only with hypervisor control and index 7.
// - Valid register exists with partitioning and hypervisor control.
// - No effect on identifiers when hypervisor level is disabled.
// - Map entries and valid bits are not initialised by reset.
// - Valid bits 31:0 one per identifier, bits 63:32 read zero.
// - Valid bit m governs entry m in map register m shifted right 2.
// - Reached by encoding op0 3, op1 4, CRn 10 with given CRm, op2.
// - Under both nested controls kernel accesses go to base plus offset.
// - User never, monitor always, hypervisor when non-secure or enabled.
// - Lower-level trap set sends hypervisor accesses to the monitor.
// - Lower trap with nested but not enhanced sends kernel to monitor.
// - Listed conditions without lower trap send kernel to hypervisor.
// - Reset sets the lower-level trap control to one.
// - Lower-level traps take priority over hypervisor-controlled traps.
// - Without hypervisor level, enables act zero and registers read zero.
`timescale 1ns/1ps
`include "vpm_defs.svh"

module vpm_upper_map_regs #(
	parameter logic [2:0] HIGHEST_MAP_REG_INDEX = 3'h7,
	parameter bit         HYP_CONTROL_PRESENT   = 1'b1,
	parameter bit         PARTITIONING_PRESENT  = 1'b1,
	parameter bit         HYP_LEVEL_PRESENT     = 1'b1
) (
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              reset,
	// Access request and core control state
	input  wire vpm_pkg::vpm_req_t req,
	input  wire vpm_pkg::vpm_ctrl_t ctrl,
	// Monitor-level trap control write
	input  wire logic              lower_trap_we,
	input  wire logic              lower_trap_wdata,
	// Identifier translation
	input  wire logic              xlate_kernel,
	input  wire logic [4:0]        xlate_vid,
	input  wire logic [15:0]       xlate_pid_in,
	// Outputs
	output vpm_pkg::vpm_rsp_t      rsp,
	output logic                   lower_level_trap,
	output logic [2:0]             highest_map_register_index,
	output logic [15:0]            xlate_pid_out,
	output logic                   xlate_mapped
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [`VPM_ENTRY_W-1:0] map_r [8];
	logic [`VPM_VALID_W-1:0] valid_r;
	logic                    lower_trap_r;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	function automatic logic [1:0] sel_of(input vpm_pkg::vpm_req_t r);
		logic base;
		base = r.op0 == `VPM_OP0 && r.op1 == `VPM_OP1 &&
			r.crn == `VPM_CRN;
		if (base && r.crm == `VPM_CRM_MAP && r.op2 == `VPM_OP2_MAP6)
			sel_of = 2'h1;
		else if (base && r.crm == `VPM_CRM_MAP && r.op2 == `VPM_OP2_MAP7)
			sel_of = 2'h2;
		else if (base && r.crm == `VPM_CRM_VALID &&
			r.op2 == `VPM_OP2_VALID)
			sel_of = 2'h3;
		else
			sel_of = 2'h0;
	endfunction : sel_of

	logic [1:0] sel;
	logic       map6_exists;
	logic       map7_exists;
	logic       valid_exists;
	logic       exists;
	logic       hyp_enabled;
	logic       nv_mem;

	assign sel = sel_of(req);
	assign map6_exists = HYP_CONTROL_PRESENT &&
		HIGHEST_MAP_REG_INDEX > `VPM_MAP6_MIN_IDX;
	assign map7_exists = HYP_CONTROL_PRESENT &&
		HIGHEST_MAP_REG_INDEX == `VPM_MAP7_IDX;
	assign valid_exists = PARTITIONING_PRESENT &&
		HYP_CONTROL_PRESENT;
	assign exists = (sel == 2'h1 && map6_exists) ||
		(sel == 2'h2 && map7_exists) || (sel == 2'h3 && valid_exists);
	assign hyp_enabled = HYP_LEVEL_PRESENT && (ctrl.non_secure_state ||
		ctrl.secure_hypervisor_enable);
	assign nv_mem = ctrl.nested_virtualisation &&
		ctrl.enhanced_nested_virtualisation;

	// ----------------------------------------------------------------
	// Access resolution
	// ----------------------------------------------------------------
	vpm_pkg::vpm_result_t res;
	logic [11:0]          nv_ofs;

	always_comb begin
		res = vpm_pkg::VPM_RES_UNDEF;
		nv_ofs = `VPM_NV_OFS_VALID;
		if (sel == 2'h1)
			nv_ofs = `VPM_NV_OFS_MAP6;
		else if (sel == 2'h2)
			nv_ofs = `VPM_NV_OFS_MAP7;
		if (exists) begin
			unique case (req.level)
				vpm_pkg::VPM_LVL_USER: begin
					res = vpm_pkg::VPM_RES_UNDEF;
				end
				vpm_pkg::VPM_LVL_MON: begin
					res = vpm_pkg::VPM_RES_OK;
				end
				vpm_pkg::VPM_LVL_HYP: begin
					if (lower_trap_r)
						res = vpm_pkg::VPM_RES_TRAP_MON;
					else if (hyp_enabled)
						res = vpm_pkg::VPM_RES_OK;
				end
				vpm_pkg::VPM_LVL_KERNEL: begin
					if (ctrl.host_trap_general_exceptions && hyp_enabled)
						res = vpm_pkg::VPM_RES_UNDEF;
					else if (nv_mem)
						res = vpm_pkg::VPM_RES_MEMORY;
					else if (lower_trap_r &&
						ctrl.nested_virtualisation)
						res = vpm_pkg::VPM_RES_TRAP_MON;
					else if (hyp_enabled && ctrl.hypervisor_64bit &&
						ctrl.host_extension && ctrl.nested_virtualisation)
						res = vpm_pkg::VPM_RES_TRAP_HYP;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Monitor-level trap control
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			lower_trap_r <= 1'b1;
		else if (lower_trap_we)
			lower_trap_r <= lower_trap_wdata;
	end

	// ----------------------------------------------------------------
	// Register writes; no reset, contents start unknown
	// ----------------------------------------------------------------
	logic do_write;
	assign do_write = req.valid && req.write &&
		res == vpm_pkg::VPM_RES_OK && HYP_LEVEL_PRESENT;

	genvar g;
	generate
		for (g = 0; g < `VPM_ENTRIES; g++) begin : g_entry
			always_ff @(posedge ref_clk) begin
				if (do_write && sel == 2'h1)
					map_r[g] <= req.wdata[g*`VPM_ENTRY_W +:
						`VPM_ENTRY_W];
				if (do_write && sel == 2'h2)
					map_r[g+`VPM_ENTRIES] <= req.wdata[g*`VPM_ENTRY_W +:
						`VPM_ENTRY_W];
			end
		end
	endgenerate

	always_ff @(posedge ref_clk) begin
		if (do_write && sel == 2'h3)
			valid_r <= req.wdata[`VPM_VALID_W-1:0];
	end

	// ----------------------------------------------------------------
	// Read data and response
	// ----------------------------------------------------------------
	logic [63:0] rd;
	always_comb begin
		rd = 64'h0;
		if (HYP_LEVEL_PRESENT) begin
			if (sel == 2'h1)
				rd = {map_r[3], map_r[2], map_r[1], map_r[0]};
			else if (sel == 2'h2)
				rd = {map_r[7], map_r[6], map_r[5], map_r[4]};
			else if (sel == 2'h3)
				rd = {32'h0, valid_r};
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			rsp <= '0;
		end else begin
			rsp.valid <= req.valid;
			rsp.result <= res;
			rsp.rdata <= (req.valid && !req.write &&
				res == vpm_pkg::VPM_RES_OK) ? rd : 64'h0;
			rsp.mem_addr <= (res == vpm_pkg::VPM_RES_MEMORY) ?
				({ctrl.base_address_field, 12'h0} +
				{52'h0, nv_ofs}) : 64'h0;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			lower_level_trap <= 1'b1;
			highest_map_register_index <= 3'h0;
		end else begin
			lower_level_trap <= lower_trap_r;
			highest_map_register_index <= HIGHEST_MAP_REG_INDEX;
		end
	end

	// ----------------------------------------------------------------
	// Identifier translation for virtual identifiers 24 to 31
	// ----------------------------------------------------------------
	logic       xl_en;
	logic       xl_hit;
	logic [2:0] xl_idx;
	logic [2:0] xl_grp;

	assign xl_grp = 3'(xlate_vid >> `VPM_GROUP_SHIFT);
	assign xl_idx = xlate_vid[2:0];
	assign xl_en = hyp_enabled && (xlate_kernel ?
		ctrl.kernel_level_map_enable :
		ctrl.user_level_map_enable);
	assign xl_hit = xl_en && ((xl_grp == 3'h6 && map6_exists) ||
		(xl_grp == 3'h7 && map7_exists)) &&
		HIGHEST_MAP_REG_INDEX != 3'h0 &&
		valid_r[xlate_vid] == 1'b1;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			xlate_pid_out <= 16'h0;
			xlate_mapped <= 1'b0;
		end else begin
			xlate_mapped <= xl_hit;
			xlate_pid_out <= xl_hit ? map_r[xl_idx] : xlate_pid_in;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Access matrix: the answer follows the request by one cycle
	a_hyp_trap_mon: assert property (
		@(posedge ref_clk) disable iff (reset)
		req.valid && exists && req.level == vpm_pkg::VPM_LVL_HYP &&
		lower_trap_r |=> rsp.result == vpm_pkg::VPM_RES_TRAP_MON)
		else $error("hyp access not trapped to monitor");
	a_user_undef: assert property (
		@(posedge ref_clk) disable iff (reset)
		req.valid && req.level == vpm_pkg::VPM_LVL_USER
		|=> rsp.result == vpm_pkg::VPM_RES_UNDEF)
		else $error("user access not undefined");
	a_mon_ok: assert property (
		@(posedge ref_clk) disable iff (reset)
		req.valid && exists && req.level == vpm_pkg::VPM_LVL_MON
		|=> rsp.result == vpm_pkg::VPM_RES_OK)
		else $error("monitor access refused");
	a_tge_undef: assert property (
		@(posedge ref_clk) disable iff (reset)
		req.valid && exists && req.level == vpm_pkg::VPM_LVL_KERNEL &&
		ctrl.host_trap_general_exceptions && hyp_enabled
		|=> rsp.result == vpm_pkg::VPM_RES_UNDEF)
		else $error("kernel access under host trap not undefined");
	a_refused_nodata: assert property (
		@(posedge ref_clk) disable iff (reset)
		rsp.valid && rsp.result != vpm_pkg::VPM_RES_OK
		|-> rsp.rdata == 64'h0)
		else $error("refused access returned data");
	a_valid_upper: assert property (
		@(posedge ref_clk) disable iff (reset)
		rsp.valid |-> rsp.rdata[63:32] == 32'h0 ||
		$past(sel) != 2'h3)
		else $error("valid register upper half nonzero");
	a_nv_addr: assert property (
		@(posedge ref_clk) disable iff (reset)
		req.valid && sel == 2'h1 && res == vpm_pkg::VPM_RES_MEMORY
		|=> rsp.mem_addr[11:0] == `VPM_NV_OFS_MAP6)
		else $error("redirect offset wrong");
	a_kern_memory: assert property (
		@(posedge ref_clk) disable iff (reset)
		req.valid && exists && req.level == vpm_pkg::VPM_LVL_KERNEL &&
		nv_mem && !ctrl.host_trap_general_exceptions
		|=> rsp.result == vpm_pkg::VPM_RES_MEMORY)
		else $error("kernel access not redirected to memory");
	a_undef_map7: assert property (
		@(posedge ref_clk) disable iff (reset)
		req.valid && sel == 2'h2 && !map7_exists
		|=> rsp.result == vpm_pkg::VPM_RES_UNDEF)
		else $error("absent register not undefined");
	a_kern_trap: assert property (
		@(posedge ref_clk) disable iff (reset)
		req.valid && exists && req.level == vpm_pkg::VPM_LVL_KERNEL &&
		lower_trap_r && ctrl.nested_virtualisation && !nv_mem &&
		!ctrl.host_trap_general_exceptions
		|=> rsp.result == vpm_pkg::VPM_RES_TRAP_MON)
		else $error("kernel access not trapped to monitor");
	a_kern_hyp_trap: assert property (
		@(posedge ref_clk) disable iff (reset)
		req.valid && exists && req.level == vpm_pkg::VPM_LVL_KERNEL &&
		!lower_trap_r && hyp_enabled && ctrl.hypervisor_64bit &&
		ctrl.host_extension && ctrl.nested_virtualisation && !nv_mem &&
		!ctrl.host_trap_general_exceptions
		|=> rsp.result == vpm_pkg::VPM_RES_TRAP_HYP)
		else $error("kernel access not trapped to hypervisor");
	a_trap_mirror: assert property (
		@(posedge ref_clk) disable iff (reset)
		lower_trap_r |=> lower_level_trap)
		else $error("trap control output does not follow state");

	// Storage: whole registers land as written, unused bits dropped
	a_store_map6: assert property (
		@(posedge ref_clk) disable iff (reset)
		do_write && sel == 2'h1
		|=> {map_r[3], map_r[2], map_r[1], map_r[0]} == $past(req.wdata))
		else $error("register six write lost");
	a_store_map7: assert property (
		@(posedge ref_clk) disable iff (reset)
		do_write && sel == 2'h2
		|=> {map_r[7], map_r[6], map_r[5], map_r[4]} == $past(req.wdata))
		else $error("register seven write lost");
	a_store_valid: assert property (
		@(posedge ref_clk) disable iff (reset)
		do_write && sel == 2'h3
		|=> valid_r == $past(req.wdata[`VPM_VALID_W-1:0]))
		else $error("valid bits write lost");

	// Translation
	a_xlate_off: assert property (
		@(posedge ref_clk) disable iff (reset)
		!hyp_enabled |=> !xlate_mapped)
		else $error("translation with hypervisor off");
	a_xlate_valid: assert property (
		@(posedge ref_clk) disable iff (reset)
		xl_hit |=> xlate_mapped && xlate_pid_out == $past(map_r[xl_idx]))
		else $error("mapped identifier wrong");
	a_xlate_pass: assert property (
		@(posedge ref_clk) disable iff (reset)
		!xl_hit |=> !xlate_mapped && xlate_pid_out == $past(xlate_pid_in))
		else $error("unmapped identifier altered");

endmodule : vpm_upper_map_regs

// *** rtl/vpm_defs.svh ***
// Constants for the upper virtual partition map registers
`ifndef VPM_DEFS_SVH
`define VPM_DEFS_SVH

// Encoding fields of the three registers; op0, op1 and CRn shared by all
`define VPM_OP0          2'h3
`define VPM_OP1          3'h4
`define VPM_CRN          4'ha
`define VPM_CRM_MAP      4'h6
`define VPM_CRM_VALID    4'h4
`define VPM_OP2_MAP6     3'h6
`define VPM_OP2_MAP7     3'h7
`define VPM_OP2_VALID    3'h1

// Offsets from the nested virtualisation base when redirected to memory
`define VPM_NV_OFS_MAP6  12'h970
`define VPM_NV_OFS_MAP7  12'h978
`define VPM_NV_OFS_VALID 12'h938
`define VPM_NV_SHIFT     12

// Entry layout and limits
`define VPM_ENTRY_W      16
`define VPM_ENTRIES      4
`define VPM_VALID_W      32
`define VPM_MAP6_MIN_IDX 3'h5
`define VPM_MAP7_IDX     3'h7
`define VPM_MAP6_BASE    5'h18
`define VPM_MAP7_BASE    5'h1c
`define VPM_GROUP_SHIFT  2

`endif

// *** rtl/vpm_pkg.sv ***
// Types for the upper virtual partition map registers
package vpm_pkg;

	typedef enum logic [1:0] {
		VPM_LVL_USER,
		VPM_LVL_KERNEL,
		VPM_LVL_HYP,
		VPM_LVL_MON
	} vpm_level_t;

	typedef enum logic [2:0] {
		VPM_RES_OK,
		VPM_RES_UNDEF,
		VPM_RES_TRAP_HYP,
		VPM_RES_TRAP_MON,
		VPM_RES_MEMORY
	} vpm_result_t;

	// One system-register access request
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [1:0] op0;
		logic [2:0] op1;
		logic [3:0] crn;
		logic [3:0] crm;
		logic [2:0] op2;
		logic [63:0] wdata;
		vpm_level_t level;
	} vpm_req_t;

	// Control state owned elsewhere in the core
	typedef struct packed {
		logic non_secure_state;
		logic secure_hypervisor_enable;
		logic hypervisor_64bit;
		logic host_extension;
		logic host_trap_general_exceptions;
		logic nested_virtualisation;
		logic enhanced_nested_virtualisation;
		logic kernel_level_map_enable;
		logic user_level_map_enable;
		logic [51:0] base_address_field;
	} vpm_ctrl_t;

	// Answer to an access
	typedef struct packed {
		logic        valid;
		vpm_result_t result;
		logic [63:0] rdata;
		logic [63:0] mem_addr;
	} vpm_rsp_t;

endpackage : vpm_pkg

// *** bench/vpm_core_model.sv ***
// Core-side model that issues system-register accesses to the map block
`timescale 1ns/1ps
`include "vpm_defs.svh"

module vpm_core_model (
	// Clock
	input  wire logic              ref_clk,
	// Access path
	output vpm_pkg::vpm_req_t      req,
	input  wire vpm_pkg::vpm_rsp_t rsp
);
	initial req = '0;

	// ------------------------------------------------------------
	// One access: request driven after one edge, taken at the next, answer read 1 ns after it
	// ------------------------------------------------------------
	task automatic acc(input vpm_pkg::vpm_level_t lv, input logic wr,
		input int sel, input logic [63:0] wd,
		output vpm_pkg::vpm_rsp_t r);
		vpm_pkg::vpm_req_t q;
		q = '0;
		q.valid = 1'b1;
		q.write = wr;
		q.op0 = `VPM_OP0;
		q.op1 = `VPM_OP1;
		q.crn = `VPM_CRN;
		q.crm = (sel == 2) ? `VPM_CRM_VALID : `VPM_CRM_MAP;
		q.op2 = (sel == 0) ? `VPM_OP2_MAP6 :
			(sel == 1) ? `VPM_OP2_MAP7 : `VPM_OP2_VALID;
		q.wdata = wd;
		q.level = lv;
		@(posedge ref_clk);
		req <= q;
		@(posedge ref_clk);
		// Released data flips so a stale value is never mistaken
		q.valid = 1'b0;
		q.wdata = ~wd;
		req <= q;
		#1 r = rsp;
	endtask : acc
endmodule : vpm_core_model

// *** bench/virtual_partition_id_map_regs_tb_top.sv ***
// Self-checking bench for the upper virtual partition map registers
`timescale 1ns/1ps

module virtual_partition_id_map_regs_tb_top;
	// ----------------------------
	// Signals
	// ----------------------------
	logic               ref_clk = 1'b0;
	logic               reset;
	vpm_pkg::vpm_req_t  req;
	vpm_pkg::vpm_ctrl_t ctrl;
	vpm_pkg::vpm_rsp_t  rsp;
	vpm_pkg::vpm_rsp_t  r;
	logic               lower_trap_we;
	logic               lower_trap_wdata;
	logic               xlate_kernel;
	logic [4:0]         xlate_vid;
	logic [15:0]        xlate_pid_in;
	logic               lower_level_trap;
	logic [2:0]         hmri;
	logic [15:0]        xlate_pid_out;
	logic               xlate_mapped;
	logic [63:0]        ex [3];
	int                 num_errors = 0;
	int                 compares = 0;
	int                 cycles = 0;

	always #2.5 ref_clk = ~ref_clk;

	vpm_upper_map_regs dut_u (.ref_clk(ref_clk), .reset(reset), .req(req),
		.ctrl(ctrl), .lower_trap_we(lower_trap_we),
		.lower_trap_wdata(lower_trap_wdata), .xlate_kernel(xlate_kernel),
		.xlate_vid(xlate_vid), .xlate_pid_in(xlate_pid_in), .rsp(rsp),
		.lower_level_trap(lower_level_trap),
		.highest_map_register_index(hmri), .xlate_pid_out(xlate_pid_out),
		.xlate_mapped(xlate_mapped));
	vpm_core_model core_u (.ref_clk(ref_clk), .req(req), .rsp(rsp));

	// ----------------------------
	// Helpers
	// ----------------------------
	task automatic chk(input string nm, input logic [63:0] seen,
		input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic give_verdict();
		$display("checks %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			give_verdict();
		end
	end

	// Readback: upper half of the valid register always zero
	function automatic logic [63:0] rb(input int s);
		return (s == 2) ? {32'h0, ex[2][31:0]} : ex[s];
	endfunction : rb

	function automatic logic [15:0] ent(input int v);
		return 16'((v < 28 ? ex[0] : ex[1]) >> (16 * (v % 4)));
	endfunction : ent

	task automatic acc_chk(input vpm_pkg::vpm_level_t lv, input logic wr,
		input int s, input logic [63:0] wd,
		input vpm_pkg::vpm_result_t er, input logic [63:0] ed);
		core_u.acc(lv, wr, s, wd, r);
		chk("rsp_valid", r.valid, 1'b1);
		chk("result", r.result, er);
		chk("rdata", r.rdata, ed);
	endtask : acc_chk

	task automatic xl(input logic k, input int v, input logic em);
		@(posedge ref_clk);
		xlate_kernel <= k;
		xlate_vid <= 5'(v);
		xlate_pid_in <= 16'h0abc;
		@(posedge ref_clk);
		#1 chk("mapped", xlate_mapped, em);
		if (em)
			chk("pid", xlate_pid_out, ent(v));
		else
			chk("pid_pass", xlate_pid_out, 16'h0abc);
	endtask : xl

	// ----------------------------
	// Scenarios
	// ----------------------------
	task automatic t_trap();
		chk("trap_rst", lower_level_trap, 1'b1);
		chk("max_index", hmri, 3'h7);
		acc_chk(vpm_pkg::VPM_LVL_HYP, 0, 0, 0,
			vpm_pkg::VPM_RES_TRAP_MON, 0);
		@(posedge ref_clk);
		ctrl.nested_virtualisation <= 1'b1;
		ctrl.host_extension <= 1'b1;
		acc_chk(vpm_pkg::VPM_LVL_KERNEL, 0, 1, 0,
			vpm_pkg::VPM_RES_TRAP_MON, 0);
		@(posedge ref_clk);
		lower_trap_we <= 1'b1;
		@(posedge ref_clk);
		lower_trap_we <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1 chk("trap_clr", lower_level_trap, 1'b0);
		acc_chk(vpm_pkg::VPM_LVL_KERNEL, 0, 2, 0,
			vpm_pkg::VPM_RES_TRAP_HYP, 0);
		@(posedge ref_clk);
		ctrl.nested_virtualisation <= 1'b0;
		ctrl.host_extension <= 1'b0;
	endtask : t_trap

	task automatic t_rw();
		for (int s = 0; s < 3; s++) begin
			acc_chk(vpm_pkg::VPM_LVL_MON, 1, s, ex[s],
				vpm_pkg::VPM_RES_OK, 0);
		end
		for (int s = 0; s < 3; s++) begin
			acc_chk(vpm_pkg::VPM_LVL_MON, 0, s, 0,
				vpm_pkg::VPM_RES_OK, rb(s));
		end
		acc_chk(vpm_pkg::VPM_LVL_USER, 0, 0, 0,
			vpm_pkg::VPM_RES_UNDEF, 0);
		acc_chk(vpm_pkg::VPM_LVL_HYP, 0, 1, 0,
			vpm_pkg::VPM_RES_OK, rb(1));
		@(posedge ref_clk);
		ctrl.host_trap_general_exceptions <= 1'b1;
		acc_chk(vpm_pkg::VPM_LVL_KERNEL, 0, 0, 0,
			vpm_pkg::VPM_RES_UNDEF, 0);
		@(posedge ref_clk);
		ctrl.host_trap_general_exceptions <= 1'b0;
		ctrl.non_secure_state <= 1'b0;
		acc_chk(vpm_pkg::VPM_LVL_HYP, 0, 0, 0,
			vpm_pkg::VPM_RES_UNDEF, 0);
		@(posedge ref_clk);
		ctrl.secure_hypervisor_enable <= 1'b1;
		acc_chk(vpm_pkg::VPM_LVL_HYP, 0, 2, 0,
			vpm_pkg::VPM_RES_OK, rb(2));
		@(posedge ref_clk);
		ctrl.non_secure_state <= 1'b1;
		ctrl.secure_hypervisor_enable <= 1'b0;
	endtask : t_rw

	task automatic t_mem();
		logic [63:0] ofs [3];
		ofs = '{64'h970, 64'h978, 64'h938};
		@(posedge ref_clk);
		ctrl.nested_virtualisation <= 1'b1;
		ctrl.enhanced_nested_virtualisation <= 1'b1;
		ctrl.base_address_field <= 52'h12345;
		for (int s = 0; s < 3; s++) begin
			acc_chk(vpm_pkg::VPM_LVL_KERNEL, 1, s, ~ex[s],
				vpm_pkg::VPM_RES_MEMORY, 0);
			chk("mem_addr", r.mem_addr, 64'h12345000 + ofs[s]);
		end
		@(posedge ref_clk);
		ctrl.nested_virtualisation <= 1'b0;
		ctrl.enhanced_nested_virtualisation <= 1'b0;
		for (int s = 0; s < 3; s++) begin
			acc_chk(vpm_pkg::VPM_LVL_MON, 0, s, 0,
				vpm_pkg::VPM_RES_OK, rb(s));
		end
	endtask : t_mem

	task automatic t_xlate();
		for (int v = 24; v < 32; v++) begin
			xl(1'b1, v, 1'b1);
		end
		ex[2] = 64'h0000_0000_f700_0000;
		acc_chk(vpm_pkg::VPM_LVL_MON, 1, 2, ex[2],
			vpm_pkg::VPM_RES_OK, 0);
		xl(1'b1, 27, 1'b0);
		xl(1'b1, 31, 1'b1);
		@(posedge ref_clk);
		ctrl.kernel_level_map_enable <= 1'b0;
		ctrl.user_level_map_enable <= 1'b1;
		xl(1'b1, 28, 1'b0);
		xl(1'b0, 28, 1'b1);
		@(posedge ref_clk);
		ctrl.non_secure_state <= 1'b0;
		xl(1'b0, 28, 1'b0);
	endtask : t_xlate

	// Mid-run reset must bring the lower-level trap back
	task automatic t_reset();
		@(posedge ref_clk);
		reset <= 1'b1;
		@(posedge ref_clk);
		reset <= 1'b0;
		#1 chk("trap_mid_rst", lower_level_trap, 1'b1);
		chk("rsp_mid_rst", rsp.valid, 1'b0);
		repeat (2) @(posedge ref_clk);
		#1 chk("trap_after_rst", lower_level_trap, 1'b1);
		acc_chk(vpm_pkg::VPM_LVL_HYP, 0, 1, 0,
			vpm_pkg::VPM_RES_TRAP_MON, 0);
	endtask : t_reset

	initial begin
		reset = 1'b1;
		ctrl = '0;
		ctrl.non_secure_state = 1'b1;
		ctrl.hypervisor_64bit = 1'b1;
		ctrl.kernel_level_map_enable = 1'b1;
		lower_trap_we = 1'b0;
		lower_trap_wdata = 1'b0;
		xlate_kernel = 1'b0;
		xlate_vid = 5'h0;
		xlate_pid_in = 16'h0;
		ex = '{64'h0a1b_0a1a_0a19_0a18, 64'h0a1f_0a1e_0a1d_0a1c,
			64'hdead_beef_ff00_0000};
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		t_trap();
		t_rw();
		t_mem();
		t_xlate();
		t_reset();
		give_verdict();
	end
endmodule : virtual_partition_id_map_regs_tb_top
